// ### design/paer_pkg.sv
package paer_pkg;

	// ****************************************
	// Bus geometry
	// ****************************************
	localparam int unsigned AXI_AW = 12;
	localparam int unsigned DW     = 32;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [AXI_AW-1:0] OFS_UNC_STS  = 12'h104;
	localparam logic [AXI_AW-1:0] OFS_UNC_SEV  = 12'h10C;
	localparam logic [AXI_AW-1:0] OFS_COR_STS  = 12'h110;
	localparam logic [AXI_AW-1:0] OFS_COR_MSK  = 12'h114;
	localparam logic [AXI_AW-1:0] OFS_CAP_CTL  = 12'h118;
	localparam logic [AXI_AW-1:0] OFS_HDR_LOG0 = 12'h11C;
	localparam logic [AXI_AW-1:0] OFS_HDR_LOG3 = 12'h128;

	// ****************************************
	// Field layouts and reset values
	// ****************************************
	localparam logic [DW-1:0] UNC_VALID     = 32'h001FF011;
	localparam logic [DW-1:0] UNC_SEV_RST   = 32'h00062011;
	localparam logic [DW-1:0] COR_VALID     = 32'h000031C1;
	localparam logic [DW-1:0] COR_MSK_RST   = 32'h00002000;
	localparam int unsigned   CAP_FEP_LSB   = 0;
	localparam int unsigned   CAP_GEN_CAP   = 5;
	localparam int unsigned   CAP_GEN_EN    = 6;
	localparam int unsigned   CAP_CHK_CAP   = 7;
	localparam int unsigned   CAP_CHK_EN    = 8;
	localparam logic [4:0]    FEP_RST       = 5'h00;
	localparam logic [1:0]    RESP_OKAY     = 2'h0;
	localparam logic [1:0]    RESP_SLVERR   = 2'h2;

	// ****************************************
	// Complete block state
	// ****************************************
	typedef struct packed {
		logic              aw_full;
		logic              aw_rdy;
		logic [AXI_AW-1:0] aw_addr;
		logic              w_full;
		logic              w_rdy;
		logic [DW-1:0]     w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              ar_rdy;
		logic              rvalid;
		logic [DW-1:0]     rdata;
		logic [1:0]        rresp;
		logic [DW-1:0]     unc_sts;
		logic [DW-1:0]     unc_sev;
		logic [DW-1:0]     cor_sts;
		logic [DW-1:0]     cor_msk;
		logic [4:0]        fep;
		logic              gen_en;
		logic              chk_en;
		logic              log_held;
		logic [127:0]      hdr;
		logic              msg_cor;
		logic              msg_nonfatal;
		logic              msg_fatal;
	} paer_state_type;

	localparam paer_state_type STATE_RST = '{
		aw_full: 1'b0, aw_rdy: 1'b1, aw_addr: '0, w_full: 1'b0, w_rdy: 1'b1,
		w_data: '0, w_strb: 4'h0, bvalid: 1'b0, bresp: RESP_OKAY, ar_rdy: 1'b1,
		rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY, unc_sts: '0, unc_sev: UNC_SEV_RST,
		cor_sts: '0, cor_msk: COR_MSK_RST, fep: FEP_RST, gen_en: 1'b0, chk_en: 1'b0,
		log_held: 1'b0, hdr: '0, msg_cor: 1'b0, msg_nonfatal: 1'b0, msg_fatal: 1'b0
	};

endpackage

// ### design/paer_regs.sv
// Operation
// - Severity bit per uncorrectable error, sticky read-write; 1 fatal, 0 non-fatal.
// - Training, link protocol, flow control, overflow, malformed default fatal.
// - Receiver error sets correctable status bit 0; write-1 clears.
// - Bad transaction packet sets correctable status bit 6; write-1 clears.
// - Bad link packet sets correctable status bit 7; write-1 clears.
// - Replay number rollover sets correctable status bit 8; write-1 clears.
// - Replay timer expiry sets correctable status bit 12; write-1 clears.
// - Advisory non-fatal sets bit 13; reserved correctable bits read zero.
// - Masked correctable event gives no header log and no message.
// - Correctable masks reset to zero, except advisory mask bit 13 at one.
// - Five-bit first error pointer, sticky read-only, resets to zero.
// - Bit 5 reads one: end-to-end CRC generation capable.
// - Sticky bit 6 enables end-to-end CRC generation, off after reset.
// - Bit 7 reads one: end-to-end CRC check capable.
// - Sticky bit 8 enables end-to-end CRC checking, off after reset.
// - Offending header kept as four sticky doublewords, first at lowest.
// - Each header doubleword big-endian, first byte in top lane.
// - Uncorrectable status bits sticky, write-1 clear, same positions as severity.
module paer_regs
	import paer_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic                        hot_reset,
	input  wire logic [paer_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [paer_pkg::DW-1:0]     s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [paer_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [paer_pkg::DW-1:0]          s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic [paer_pkg::DW-1:0]     unc_event,
	input  wire logic [paer_pkg::DW-1:0]     unc_mask,
	input  wire logic [paer_pkg::DW-1:0]     cor_event,
	input  wire logic [127:0]                hdr_bytes,
	output logic                             msg_cor,
	output logic                             msg_nonfatal,
	output logic                             msg_fatal,
	output logic                             ecrc_gen_en,
	output logic                             ecrc_chk_en
);
	import paer_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [DW-1:0] byte_mask(input logic [3:0] strb);
		byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// First header byte to the top lane of each doubleword
	function automatic logic [127:0] hdr_swap(input logic [127:0] b);
		logic [127:0] o;
		o = '0;
		for (int d = 0; d < 4; d++) begin
			for (int k = 0; k < 4; k++) begin
				o[d*32 + (3-k)*8 +: 8] = b[d*32 + k*8 +: 8];
			end
		end
		hdr_swap = o;
	endfunction

	function automatic logic [4:0] lowest_bit(input logic [DW-1:0] v);
		logic [4:0] idx;
		idx = 5'h00;
		for (int i = DW - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 5'(i);
			end
		end
		lowest_bit = idx;
	endfunction

	function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
		logic h;
		h = 1'b0;
		if (a == OFS_UNC_STS) begin
			h = 1'b1;
		end else if (a == OFS_UNC_SEV) begin
			h = 1'b1;
		end else if (a == OFS_COR_STS) begin
			h = 1'b1;
		end else if (a == OFS_COR_MSK) begin
			h = 1'b1;
		end else if (a == OFS_CAP_CTL) begin
			h = 1'b1;
		end else if (a >= OFS_HDR_LOG0 && a <= OFS_HDR_LOG3 && a[1:0] == 2'h0) begin
			h = 1'b1;
		end
		reg_hit = h;
	endfunction

	function automatic logic [DW-1:0] reg_read(input logic [AXI_AW-1:0] a,
			input paer_state_type s);
		logic [DW-1:0] d;
		logic [AXI_AW-1:0] rel;
		d = '0;
		rel = a - OFS_HDR_LOG0;
		if (a == OFS_UNC_STS) begin
			d = s.unc_sts;
		end else if (a == OFS_UNC_SEV) begin
			d = s.unc_sev;
		end else if (a == OFS_COR_STS) begin
			d = s.cor_sts;
		end else if (a == OFS_COR_MSK) begin
			d = s.cor_msk;
		end else if (a == OFS_CAP_CTL) begin
			d[CAP_GEN_CAP] = 1'b1;
			d[CAP_CHK_CAP] = 1'b1;
			d[CAP_GEN_EN] = s.gen_en;
			d[CAP_CHK_EN] = s.chk_en;
			d[CAP_FEP_LSB +: 5] = s.fep;
		end else if (a >= OFS_HDR_LOG0 && a <= OFS_HDR_LOG3 && a[1:0] == 2'h0) begin
			d = s.hdr[rel[3:2]*32 +: 32];
		end
		reg_read = d;
	endfunction

	// ****************************************
	// State
	// ****************************************
	paer_state_type s_r;
	paer_state_type s_nxt;
	logic           do_wr;
	logic [DW-1:0]  wbits;
	logic [DW-1:0]  unc_new;
	logic [DW-1:0]  cor_live;
	logic           log_take;

	always_comb begin
		s_nxt = s_r;
		s_nxt.msg_cor = 1'b0;
		s_nxt.msg_nonfatal = 1'b0;
		s_nxt.msg_fatal = 1'b0;
		do_wr = s_r.aw_full && s_r.w_full && !s_r.bvalid;
		wbits = s_r.w_data & byte_mask(s_r.w_strb);
		unc_new = unc_event & UNC_VALID & ~unc_mask;
		cor_live = cor_event & COR_VALID & ~s_r.cor_msk;
		log_take = 1'b0;

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && s_r.aw_rdy) begin
			s_nxt.aw_full = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.w_rdy) begin
			s_nxt.w_full = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (do_wr) begin
			s_nxt.aw_full = 1'b0;
			s_nxt.w_full = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = reg_hit(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (s_r.aw_addr == OFS_UNC_STS) begin
				s_nxt.unc_sts = s_r.unc_sts & ~wbits;
			end else if (s_r.aw_addr == OFS_UNC_SEV) begin
				s_nxt.unc_sev = ((s_r.unc_sev & ~byte_mask(s_r.w_strb)) | wbits) & UNC_VALID;
			end else if (s_r.aw_addr == OFS_COR_STS) begin
				s_nxt.cor_sts = s_r.cor_sts & ~wbits;
			end else if (s_r.aw_addr == OFS_COR_MSK) begin
				s_nxt.cor_msk = ((s_r.cor_msk & ~byte_mask(s_r.w_strb)) | wbits) & COR_VALID;
			end else if (s_r.aw_addr == OFS_CAP_CTL && s_r.w_strb[1]) begin
				s_nxt.chk_en = s_r.w_data[CAP_CHK_EN];
			end
			if (s_r.aw_addr == OFS_CAP_CTL && s_r.w_strb[0]) begin
				s_nxt.gen_en = s_r.w_data[CAP_GEN_EN];
			end
		end
		s_nxt.aw_rdy = !s_nxt.aw_full;
		s_nxt.w_rdy = !s_nxt.w_full;

		// Read channel: one read in flight
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_r.ar_rdy) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = reg_read(s_axi_araddr, s_r);
			s_nxt.rresp = reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		s_nxt.ar_rdy = !s_nxt.rvalid;

		// Event capture: a set in the clearing cycle wins
		// status set
		s_nxt.cor_sts = s_nxt.cor_sts | (cor_event & COR_VALID);
		s_nxt.cor_sts = s_nxt.cor_sts & COR_VALID;
		s_nxt.unc_sts = (s_nxt.unc_sts | unc_event) & UNC_VALID;

		// hold released once logged bit cleared
		if (s_r.log_held && !s_nxt.unc_sts[s_r.fep]) begin
			s_nxt.log_held = 1'b0;
		end
		if (!s_r.log_held && unc_new != '0) begin
			log_take = 1'b1;
			s_nxt.log_held = 1'b1;
			s_nxt.fep = lowest_bit(unc_new);
			s_nxt.hdr = hdr_swap(hdr_bytes);
		end

		s_nxt.msg_cor = cor_live != '0;
		s_nxt.msg_fatal = (unc_new & s_r.unc_sev) != '0;
		s_nxt.msg_nonfatal = (unc_new & ~s_r.unc_sev) != '0;

		// ordinary reset touches bus state and message pulses only
		if (hot_reset) begin
			s_nxt.aw_full = STATE_RST.aw_full;
			s_nxt.aw_rdy = STATE_RST.aw_rdy;
			s_nxt.w_full = STATE_RST.w_full;
			s_nxt.w_rdy = STATE_RST.w_rdy;
			s_nxt.bvalid = STATE_RST.bvalid;
			s_nxt.rvalid = STATE_RST.rvalid;
			s_nxt.ar_rdy = STATE_RST.ar_rdy;
			s_nxt.msg_cor = 1'b0;
			s_nxt.msg_nonfatal = 1'b0;
			s_nxt.msg_fatal = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign s_axi_awready = s_r.aw_rdy;
	assign s_axi_wready  = s_r.w_rdy;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_arready = s_r.ar_rdy;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;
	assign s_axi_rvalid  = s_r.rvalid;
	assign msg_cor       = s_r.msg_cor;
	assign msg_nonfatal  = s_r.msg_nonfatal;
	assign msg_fatal     = s_r.msg_fatal;
	assign ecrc_gen_en   = s_r.gen_en;
	assign ecrc_chk_en   = s_r.chk_en;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	rx_err_set_a: assert property (cor_event[0] |=> s_r.cor_sts[0])
		else $error("receiver error not recorded");

	bad_tlp_clr_a: assert property ((do_wr && s_r.aw_addr == OFS_COR_STS && wbits[6]
		&& !cor_event[6] && !hot_reset) |=> !s_r.cor_sts[6])
		else $error("bad packet status not cleared");

	cor_rsvd_a: assert property ((s_r.cor_sts & ~COR_VALID) == '0)
		else $error("reserved correctable bit set");

	cor_mask_a: assert property (((cor_event & COR_VALID & ~s_r.cor_msk) == '0)
		|=> !msg_cor)
		else $error("message for masked event");

	cap_bits_a: assert property ((s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_CAP_CTL
		&& !hot_reset) |=> s_axi_rvalid && s_axi_rdata[7] && s_axi_rdata[5])
		else $error("capability bits not read as one");

	fep_hold_a: assert property ((s_r.log_held && s_nxt.log_held)
		|=> $stable(s_r.fep) && $stable(s_r.hdr))
		else $error("first error log overwritten");

	hdr_swap_a: assert property (log_take
		|=> s_r.hdr[31:24] == $past(hdr_bytes[7:0]) && s_r.hdr[7:0] == $past(hdr_bytes[31:24]))
		else $error("header byte order wrong");

	fatal_msg_a: assert property (((unc_event & UNC_VALID & ~unc_mask & s_r.unc_sev) != '0
		&& !hot_reset) |=> msg_fatal)
		else $error("fatal message missing");

	wr_resp_a: assert property ((do_wr && !hot_reset) |=> s_axi_bvalid)
		else $error("write response late");

endmodule // paer_regs

// ### tb/paer_link_model.sv
module paer_link_model
	import paer_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    msg_cor,
	input  wire logic                    msg_nonfatal,
	input  wire logic                    msg_fatal,
	output logic [paer_pkg::DW-1:0]      unc_event,
	output logic [paer_pkg::DW-1:0]      cor_event,
	output logic [127:0]                 hdr_bytes
);
	timeunit 1ns;
	timeprecision 1ps;
	int n_cor = 0;
	int n_nf = 0;
	int n_fat = 0;
	initial begin
		unc_event = '0;
		cor_event = '0;
		hdr_bytes = '0;
	end
	// Messages are one-cycle pulses, so count every sampled high
	always @(posedge clk) begin
		if (msg_cor === 1'b1) n_cor++;
		if (msg_nonfatal === 1'b1) n_nf++;
		if (msg_fatal === 1'b1) n_fat++;
	end
	// Header lines show inverted junk after the pulse, never the old value
	task automatic send(input logic [31:0] u, input logic [31:0] c, input logic [127:0] h);
		@(posedge clk);
		unc_event <= u;
		cor_event <= c;
		hdr_bytes <= h;
		@(posedge clk);
		unc_event <= '0;
		cor_event <= '0;
		hdr_bytes <= ~h;
	endtask
endmodule // paer_link_model

// ### tb/tb_pcie_advanced_error_regs.sv
module tb_pcie_advanced_error_regs
	import paer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk = 1'b0;
	logic              nrst, hot_reset;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0]        s_axi_awprot, s_axi_arprot;
	logic [DW-1:0]     s_axi_wdata, s_axi_rdata, unc_mask, unc_event, cor_event;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic [127:0]      hdr_bytes;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic              msg_cor, msg_nonfatal, msg_fatal, ecrc_gen_en, ecrc_chk_en;
	int                err_count = 0;
	int                cmp_count = 0;
	int                c0, nf0, f0;

	paer_regs dut (
		.clk, .nrst, .hot_reset, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .unc_event, .unc_mask,
		.cor_event, .hdr_bytes, .msg_cor, .msg_nonfatal, .msg_fatal, .ecrc_gen_en, .ecrc_chk_en
	);
	paer_link_model link (
		.clk, .msg_cor, .msg_nonfatal, .msg_fatal, .unc_event, .cor_event, .hdr_bytes
	);

	always #10 clk = ~clk;

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bvalid), 32'h1);
		chk(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		s_axi_rready <= 1'b0;
		chk(32'(s_axi_rvalid), 32'h1);
		chk(s_axi_rdata, e);
		chk(32'(s_axi_rresp), 32'(er));
	endtask
	task automatic snap();
		c0 = link.n_cor;
		nf0 = link.n_nf;
		f0 = link.n_fat;
	endtask
	task automatic dmsg(input int dc, input int dnf, input int df);
		chk(link.n_cor - c0, dc);
		chk(link.n_nf - nf0, dnf);
		chk(link.n_fat - f0, df);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rdc(12'h10C, 32'h00062011);
		rdc(12'h110, 32'h0);
		rdc(12'h114, 32'h00002000);
		rdc(12'h118, 32'h000000A0);
		for (int i = 0; i < 4; i++) rdc(12'h11C + 12'(4 * i), 32'h0);
		rdc(12'h104, 32'h0);
		chk(32'({ecrc_gen_en, ecrc_chk_en}), 32'h0);
		rdc(12'h100, 32'h0, RESP_SLVERR);
		wr(12'h200, 32'hFFFFFFFF, RESP_SLVERR);
		$display("reset test done");
	endtask
	task automatic t_ctl();
		wr(12'h118, 32'hFFFFFFFF);
		rdc(12'h118, 32'h000001E0);
		chk(32'({ecrc_gen_en, ecrc_chk_en}), 32'h3);
		wr(12'h118, 32'h00000040);
		rdc(12'h118, 32'h000000E0);
		chk(32'({ecrc_gen_en, ecrc_chk_en}), 32'h2);
		$display("control test done");
	endtask
	task automatic t_cor();
		int cbit[6] = '{0, 6, 7, 8, 12, 13};
		logic [31:0] b;
		wr(12'h114, 32'hFFFFFFFF);
		rdc(12'h114, 32'h000031C1);
		wr(12'h114, 32'h0);
		foreach (cbit[i]) begin
			b = 32'h1 << cbit[i];
			snap();
			link.send(32'h0, b, '1);
			rdc(12'h110, b);
			dmsg(1, 0, 0);
			wr(12'h110, ~b);
			rdc(12'h110, b);
			wr(12'h110, b);
			rdc(12'h110, 32'h0);
		end
		link.send(32'h0, '1, '1);
		rdc(12'h110, 32'h000031C1);
		wr(12'h114, 32'h000031C1);
		snap();
		link.send(32'h0, '1, '1);
		rdc(12'h11C, 32'h0);
		dmsg(0, 0, 0);
		wr(12'h110, 32'hFFFFFFFF);
		$display("correctable test done");
	endtask
	task automatic t_unc();
		logic [127:0] h;
		for (int n = 0; n < 16; n++) h[8*n +: 8] = 8'hA0 + 8'(n);
		snap();
		link.send(32'h1 << 18, 32'h0, h);
		rdc(12'h104, 32'h00040000);
		dmsg(0, 0, 1);
		rdc(12'h118, 32'h000000F2);
		rdc(12'h11C, 32'hA0A1A2A3);
		rdc(12'h120, 32'hA4A5A6A7);
		rdc(12'h124, 32'hA8A9AAAB);
		rdc(12'h128, 32'hACADAEAF);
		snap();
		link.send(32'h1 << 12, 32'h0, ~h);
		rdc(12'h118, 32'h000000F2);
		dmsg(0, 1, 0);
		rdc(12'h11C, 32'hA0A1A2A3);
		wr(12'h104, 32'h00040000);
		rdc(12'h104, 32'h00001000);
		wr(12'h10C, 32'hFFFFFFFF);
		rdc(12'h10C, 32'h001FF011);
		snap();
		link.send(32'h1 << 12, 32'h0, h);
		rdc(12'h118, 32'h000000EC);
		dmsg(0, 0, 1);
		wr(12'h10C, 32'h0);
		snap();
		link.send(32'h1 << 18, 32'h0, ~h);
		rdc(12'h118, 32'h000000EC);
		dmsg(0, 1, 0);
		unc_mask <= 32'h1 << 20;
		snap();
		link.send(32'h1 << 20, 32'h0, h);
		rdc(12'h11C, 32'hA0A1A2A3);
		dmsg(0, 0, 0);
		unc_mask <= 32'h0;
		wr(12'h104, 32'hFFFFFFFF);
		rdc(12'h104, 32'h0);
		$display("uncorrectable test done");
	endtask
	task automatic t_sticky();
		wr(12'h10C, 32'h00000011);
		wr(12'h118, 32'h00000140);
		link.send(32'h10, 32'h0, {4{32'h12345678}});
		@(posedge clk);
		hot_reset <= 1'b1;
		@(posedge clk);
		hot_reset <= 1'b0;
		rdc(12'h10C, 32'h00000011);
		rdc(12'h114, 32'h000031C1);
		rdc(12'h118, 32'h000001E4);
		rdc(12'h104, 32'h00000010);
		rdc(12'h11C, 32'h78563412);
		chk(32'({ecrc_gen_en, ecrc_chk_en}), 32'h3);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		$display("sticky test done");
	endtask

	// ****************************************
	// Run
	// ****************************************
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		nrst = 1'b0;
		hot_reset = 1'b0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_awprot = 3'h0;
		s_axi_arprot = 3'h0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		unc_mask = '0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_ctl();
		t_cor();
		t_unc();
		t_sticky();
		conclude();
	end
	// Whole run needs a few hundred cycles; this bound only cuts a hang
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		conclude();
	end
endmodule // tb_pcie_advanced_error_regs
